//--- rtl/temp_alert_pkg.sv
// Constants, types and timing for the temperature conversion and limit alert block
package temp_alert_pkg;
  // ==========================================================
  // Clock and conversion timing
  localparam int CLK_MHZ = 100;
  localparam real CONV_TIME_MS = 15.5;
  localparam int CONV_CYCLES_DFLT = int'(CONV_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int MS_CYCLES_DFLT = 1000 * CLK_MHZ;
  // Cycle period per cycle_time_field code, in ms
  localparam logic [13:0] CYCLE_MS [8] = '{14'h0010, 14'h007D, 14'h00FA, 14'h01F4,
                                           14'h03E8, 14'h0FA0, 14'h1F40, 14'h3E80};
  // Averaging count per averaging_field code, as a power of two
  localparam logic [2:0] AVG_SHIFT [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
  localparam int MAX_AVG_SHIFT = 5;
  localparam int RESULT_W = 16;
  localparam int SUM_W = RESULT_W + MAX_AVG_SHIFT + 1;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h8000;

  // ==========================================================
  // Conversion mode codes
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_SHUT = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;

  typedef enum logic [1:0] {
    ST_SHUT = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_STANDBY = 2'b10
  } conv_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] conversion_mode_field;
    logic [2:0] cycle_time_field;
    logic [1:0] averaging_field;
    logic ready_on_pin_select;
    logic therm_alert_select;
    logic pin_polarity;
  } cfg_t;

  typedef struct packed {
    logic cfg_write;
    logic cfg_read;
    logic result_read;
    logic alert_response;
  } host_evt_t;

  typedef struct packed {
    logic [RESULT_W-1:0] high;
    logic [RESULT_W-1:0] low;
  } limits_t;

  localparam cfg_t RESET_CFG = '{conversion_mode_field: MODE_CONT, cycle_time_field: 3'h4,
                                 averaging_field: 2'h1, ready_on_pin_select: 1'b0,
                                 therm_alert_select: 1'b0, pin_polarity: 1'b0};
  localparam logic RESET_PIN = 1'b1;
endpackage : temp_alert_pkg

//--- rtl/temp_conversion_and_limit_alert.sv
// Conversion sequencer, averaging, result register and limit alert logic
`timescale 1ns/10ps

// Functional notes
// - Mode code 00 runs conversions repeatedly without host action.
// - Each continuous cycle is active conversion then standby, timed by cycle and averaging fields.
// - Result register is written at the end of the last conversion of each averaging set.
// - With averaging, the selected number of samples is summed and the mean reported.
// - One conversion lasts 15.5 ms; active time scales with the averaging count.
// - Reset defaults: eight averages, one second cycle.
// - Ready flag sets on completion, clears on config or result read.
// - Ready-on-pin select puts the ready flag on the event pin.
// - Writing 01 aborts any conversion and enters shutdown.
// - Writing 10 in shutdown runs one averaging set of conversions, then shutdown again.
// - Single shot has no standby; cycle field has no effect.
// - Alert select 0: window mode compares each result with both limits.
// - Window mode sets upper flag above high, lower flag below low.
// - Window mode: config read clears both limit flags.
// - Window mode pin asserts on a flag; config read or alert response clears.
// - Pin polarity selects the active level of the event pin.
// - Alert select 1: upper flag sets above high, clears below low.
// - Over-temperature mode holds the lower flag at zero.
// - Over-temperature mode: config reads leave limit flags alone.
// - Over-temperature mode: pin follows the upper flag only.
// - Limits share the 16-bit two's complement result format.
module temp_conversion_and_limit_alert #(
  parameter int CONV_CYCLES = temp_alert_pkg::CONV_CYCLES_DFLT,
  parameter int MS_CYCLES = temp_alert_pkg::MS_CYCLES_DFLT
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic reset_n_i, // Async reset, active low
  input wire temp_alert_pkg::cfg_t cfg_i, // Config value for a write
  input wire temp_alert_pkg::host_evt_t host_evt_i, // One-cycle host access pulses
  input wire temp_alert_pkg::limits_t limits_i, // High and low limits
  input wire logic [15:0] sample_i, // Raw conversion sample, same domain
  output temp_alert_pkg::cfg_t cfg_o, // Config register readback
  output temp_alert_pkg::conv_state_t state_o, // Sequencer state
  output logic [15:0] temp_result_o, // Temperature result register
  output logic result_ready_flag_o, // Result ready flag
  output logic upper_limit_flag_o, // High limit status
  output logic lower_limit_flag_o, // Low limit status
  output logic limit_event_pin_o // Alert pin level
);
  import temp_alert_pkg::*;

  if (CONV_CYCLES < 2 || MS_CYCLES < 1) begin : g_bad_param
    $error("CONV_CYCLES must be at least 2 and MS_CYCLES at least 1");
  end

  // ==========================================================
  // Configuration register
  cfg_t cfg;
  cfg_t next_cfg;
  logic set_done;
  logic oneshot;

  always_comb begin
    next_cfg = cfg;
    if (host_evt_i.cfg_write) begin
      next_cfg = cfg_i;
    end
    if (set_done && oneshot && !host_evt_i.cfg_write) begin
      next_cfg.conversion_mode_field = MODE_SHUT;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg <= RESET_CFG;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Conversion sequencer
  conv_state_t state;
  conv_state_t next_state;
  logic next_oneshot;
  logic [31:0] conv_cnt;
  logic [31:0] next_conv_cnt;
  logic [31:0] elapsed;
  logic [31:0] next_elapsed;
  logic [5:0] nconv;
  logic [5:0] next_nconv;
  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] next_sum;
  logic signed [SUM_W-1:0] sum_total;
  logic [2:0] avg_shift;
  logic [5:0] last_conv;
  logic [31:0] period;
  logic conv_end;
  logic [15:0] avg_value;
  logic wr_cont;
  logic wr_shut;
  logic wr_oneshot;

  assign avg_shift = AVG_SHIFT[cfg.averaging_field];
  assign last_conv = 6'((7'h01 << avg_shift) - 7'h01);
  assign period = 32'(CYCLE_MS[cfg.cycle_time_field]) * 32'(MS_CYCLES);
  assign conv_end = (state == ST_ACTIVE) && (conv_cnt == 32'(CONV_CYCLES - 1));
  assign sum_total = sum + SUM_W'($signed(sample_i));
  assign avg_value = 16'(sum_total >>> avg_shift);
  assign set_done = conv_end && (nconv == last_conv);
  assign wr_cont = host_evt_i.cfg_write && (cfg_i.conversion_mode_field == MODE_CONT);
  assign wr_shut = host_evt_i.cfg_write && (cfg_i.conversion_mode_field == MODE_SHUT);
  assign wr_oneshot = host_evt_i.cfg_write && (cfg_i.conversion_mode_field == MODE_ONESHOT);

  always_comb begin
    next_state = state;
    next_oneshot = oneshot;
    next_conv_cnt = conv_cnt;
    next_elapsed = elapsed;
    next_nconv = nconv;
    next_sum = sum;
    unique case (state)
      ST_SHUT: begin
        if (wr_cont || wr_oneshot) begin
          next_state = ST_ACTIVE;
          next_oneshot = wr_oneshot;
          next_conv_cnt = 32'h0000_0000;
          next_elapsed = 32'h0000_0000;
          next_nconv = 6'h00;
          next_sum = '0;
        end
      end
      ST_ACTIVE: begin
        next_elapsed = elapsed + 32'h0000_0001;
        next_conv_cnt = conv_cnt + 32'h0000_0001;
        if (conv_end) begin
          next_conv_cnt = 32'h0000_0000;
          next_sum = sum_total;
          next_nconv = nconv + 6'h01;
          if (set_done) begin
            next_sum = '0;
            next_nconv = 6'h00;
            next_state = oneshot ? ST_SHUT : ST_STANDBY;
            next_oneshot = 1'b0;
          end
        end
      end
      ST_STANDBY: begin
        next_elapsed = elapsed + 32'h0000_0001;
        if (next_elapsed >= period) begin
          next_state = ST_ACTIVE;
          next_elapsed = 32'h0000_0000;
        end
      end
      default: begin
        next_state = ST_SHUT;
      end
    endcase
    if (wr_cont) begin
      next_oneshot = 1'b0;
    end
    if (wr_shut) begin
      next_state = ST_SHUT;
      next_oneshot = 1'b0;
      next_conv_cnt = 32'h0000_0000;
      next_nconv = 6'h00;
      next_sum = '0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_ACTIVE;
      oneshot <= 1'b0;
      conv_cnt <= 32'h0000_0000;
      elapsed <= 32'h0000_0000;
      nconv <= 6'h00;
      sum <= '0;
    end else begin
      state <= next_state;
      oneshot <= next_oneshot;
      conv_cnt <= next_conv_cnt;
      elapsed <= next_elapsed;
      nconv <= next_nconv;
      sum <= next_sum;
    end
  end

  // ==========================================================
  // Result, ready flag, limit flags and pin
  logic [15:0] temp_result;
  logic [15:0] next_temp_result;
  logic ready;
  logic next_ready;
  logic upper;
  logic next_upper;
  logic lower;
  logic next_lower;
  logic alert;
  logic next_alert;
  logic pin;
  logic next_pin;
  logic above_high;
  logic below_low;
  logic pin_src;

  assign above_high = $signed(avg_value) > $signed(limits_i.high);
  assign below_low = $signed(avg_value) < $signed(limits_i.low);

  always_comb begin
    next_temp_result = temp_result;
    next_ready = ready;
    next_upper = upper;
    next_lower = lower;
    next_alert = alert;
    if (set_done) begin
      next_temp_result = avg_value;
    end
    if (host_evt_i.cfg_read || host_evt_i.result_read) begin
      next_ready = 1'b0;
    end
    if (set_done) begin
      next_ready = 1'b1;
    end
    if (cfg.therm_alert_select) begin
      next_lower = 1'b0;
      next_alert = 1'b0;
      if (set_done && above_high) begin
        next_upper = 1'b1;
      end else if (set_done && below_low) begin
        next_upper = 1'b0;
      end
    end else begin
      if (host_evt_i.cfg_read) begin
        next_upper = 1'b0;
        next_lower = 1'b0;
        next_alert = 1'b0;
      end
      if (host_evt_i.alert_response) begin
        next_alert = 1'b0;
      end
      if (set_done && above_high) begin
        next_upper = 1'b1;
        next_alert = 1'b1;
      end
      if (set_done && below_low) begin
        next_lower = 1'b1;
        next_alert = 1'b1;
      end
    end
    if (next_cfg.therm_alert_select) begin
      next_lower = 1'b0;
    end
    if (cfg.ready_on_pin_select) begin
      pin_src = next_ready;
    end else if (cfg.therm_alert_select) begin
      pin_src = next_upper;
    end else begin
      pin_src = next_alert;
    end
    next_pin = cfg.pin_polarity ? pin_src : !pin_src;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_result <= RESULT_RESET;
      ready <= 1'b0;
      upper <= 1'b0;
      lower <= 1'b0;
      alert <= 1'b0;
      pin <= RESET_PIN;
    end else begin
      temp_result <= next_temp_result;
      ready <= next_ready;
      upper <= next_upper;
      lower <= next_lower;
      alert <= next_alert;
      pin <= next_pin;
    end
  end

  assign cfg_o = cfg;
  assign state_o = state;
  assign temp_result_o = temp_result;
  assign result_ready_flag_o = ready;
  assign upper_limit_flag_o = upper;
  assign lower_limit_flag_o = lower;
  assign limit_event_pin_o = pin;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_set_done_cc;
    set_done && !oneshot && !host_evt_i.cfg_write;
  endsequence

  sequence s_enter_standby;
    state == ST_STANDBY;
  endsequence

  a_ready_on_done: assert property (set_done |=> ready)
    else $error("ready flag not set after completion");
  a_result_update: assert property (set_done |=> temp_result == $past(avg_value))
    else $error("result not updated with the mean");
  a_shutdown_abort: assert property (wr_shut |=> state == ST_SHUT && nconv == 6'h00)
    else $error("shutdown write did not abort");
  a_oneshot_return: assert property (set_done && oneshot && !host_evt_i.cfg_write |=> state == ST_SHUT)
    else $error("single shot did not return to shutdown");
  a_standby_follows: assert property (s_set_done_cc |=> s_enter_standby)
    else $error("continuous cycle lacks standby");
  a_lower_zero_therm: assert property (cfg.therm_alert_select |-> !lower)
    else $error("lower flag set in over-temperature mode");
  a_window_read_clear: assert property (!cfg.therm_alert_select && host_evt_i.cfg_read && !set_done
    |=> !upper && !lower)
    else $error("config read did not clear window flags");
  a_therm_read_keep: assert property (cfg.therm_alert_select && host_evt_i.cfg_read && !set_done
    |=> $stable(upper))
    else $error("config read changed flag in over-temperature mode");
  a_therm_pin_follow: assert property (cfg.therm_alert_select && !cfg.ready_on_pin_select
    |=> pin == (cfg.pin_polarity ? upper : !upper) || $changed(cfg))
    else $error("pin does not follow upper flag");
  a_conv_start: assert property ($rose(state == ST_ACTIVE) |-> conv_cnt == 32'h0000_0000)
    else $error("conversion did not start from zero");
  a_conv_length: assert property (state == ST_ACTIVE && !conv_end && !wr_shut
    |=> state == ST_ACTIVE && conv_cnt == $past(conv_cnt) + 32'h0000_0001)
    else $error("conversion counter did not advance");
endmodule : temp_conversion_and_limit_alert

//--- verification/host_model.sv
// Host side model: config writes, register reads, limits and raw samples
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i, // Block clock
  output temp_alert_pkg::cfg_t cfg_o, // Config value for a write
  output temp_alert_pkg::host_evt_t host_evt_o, // Access pulses
  output temp_alert_pkg::limits_t limits_o, // Limit registers
  output logic [15:0] sample_o // Raw sample
);
  import temp_alert_pkg::*;
  initial begin
    cfg_o = RESET_CFG;
    host_evt_o = '0;
    limits_o = '{high: 16'h0080, low: 16'hFF00};
    sample_o = 16'h0100;
  end
  // One access pulse, held across one sampling edge
  task automatic access(input host_evt_t e, input cfg_t c);
    @(posedge clk_i);
    cfg_o <= c;
    host_evt_o <= e;
    @(posedge clk_i);
    host_evt_o <= '0;
  endtask : access
endmodule : host_model

//--- verification/testbench.sv
// Self-checking bench for the conversion and limit alert block
`timescale 1ns/10ps
module testbench;
  import temp_alert_pkg::*;
  localparam int N = 4;
  localparam int MS = 2;
  logic clk_i;
  logic reset_n_i;
  cfg_t cfg_i;
  cfg_t cfg_o;
  host_evt_t host_evt_i;
  limits_t limits_i;
  logic [15:0] sample_i;
  logic [15:0] temp_result_o;
  conv_state_t state_o;
  logic result_ready_flag_o;
  logic upper_limit_flag_o;
  logic lower_limit_flag_o;
  logic limit_event_pin_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int k;
  int t0;

  host_model host (.clk_i(clk_i), .cfg_o(cfg_i), .host_evt_o(host_evt_i), .limits_o(limits_i), .sample_o(sample_i));
  temp_conversion_and_limit_alert #(.CONV_CYCLES(N), .MS_CYCLES(MS)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i), .host_evt_i(host_evt_i), .limits_i(limits_i),
    .sample_i(sample_i), .cfg_o(cfg_o), .state_o(state_o), .temp_result_o(temp_result_o),
    .result_ready_flag_o(result_ready_flag_o), .upper_limit_flag_o(upper_limit_flag_o),
    .lower_limit_flag_o(lower_limit_flag_o), .limit_event_pin_o(limit_event_pin_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // ==========================================================
  // Helpers
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic cfg_t mk(input logic [1:0] m, input logic [2:0] cy, input logic [1:0] av,
                              input logic rp, input logic th, input logic po);
    mk = '{m, cy, av, rp, th, po};
  endfunction : mk
  task automatic ev(input host_evt_t e);
    host.access(e, cfg_o);
    #1;
  endtask : ev
  task automatic wait_ready(input int bound);
    k = 0;
    while (result_ready_flag_o !== 1'b1 && k < bound) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k >= bound) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_ready
  task automatic shot(input logic [1:0] av, input logic rp, input logic th, input logic po, input logic [15:0] s);
    ev(4'h2);
    host.sample_o <= s;
    host.access(4'h8, mk(MODE_ONESHOT, 3'h7, av, rp, th, po));
    wait_ready(300);
  endtask : shot

  // ==========================================================
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    check("reset cfg", cfg_o, RESET_CFG);
    check("reset result", temp_result_o, 16'h8000);
    check("reset pin", limit_event_pin_o, 1'b1);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    wait_ready(60);
    check("avg8 time", k >= 8 * N - 1 && k <= 8 * N + 2, 1'b1);
    check("result", temp_result_o, 16'h0100);
    check("upper", upper_limit_flag_o, 1'b1);
    check("pin low", limit_event_pin_o, 1'b0);
    ev(4'h4);
    check("ready", result_ready_flag_o, 1'b0);
    check("upper", upper_limit_flag_o, 1'b0);
    check("pin", limit_event_pin_o, 1'b1);
    host.access(4'h8, mk(MODE_SHUT, 3'h4, 2'h1, 1'b0, 1'b0, 1'b0));
    #1;
    check("shut", state_o, ST_SHUT);
    shot(2'h0, 1'b0, 1'b0, 1'b0, 16'hFE00);
    check("shot time", k >= N && k <= N + 1, 1'b1);
    check("shot result", temp_result_o, 16'hFE00);
    check("signed upper", upper_limit_flag_o, 1'b0);
    check("lower", lower_limit_flag_o, 1'b1);
    check("pin", limit_event_pin_o, 1'b0);
    check("back to shut", state_o, ST_SHUT);
    check("mode", cfg_o.conversion_mode_field, MODE_SHUT);
    ev(4'h1);
    check("alert resp pin", limit_event_pin_o, 1'b1);
    ev(4'h2);
    check("ready", result_ready_flag_o, 1'b0);
    ev(4'h4);
    shot(2'h0, 1'b1, 1'b0, 1'b1, 16'h0000);
    check("ready pin", limit_event_pin_o, 1'b1);
    check("in window", {upper_limit_flag_o, lower_limit_flag_o}, 2'h0);
    ev(4'h2);
    check("ready pin", limit_event_pin_o, 1'b0);
    shot(2'h0, 1'b0, 1'b1, 1'b1, 16'h0100);
    check("therm upper", upper_limit_flag_o, 1'b1);
    ev(4'h4);
    ev(4'h1);
    check("therm upper kept", upper_limit_flag_o, 1'b1);
    check("therm pin kept", limit_event_pin_o, 1'b1);
    shot(2'h0, 1'b0, 1'b1, 1'b1, 16'h0000);
    check("hysteresis", upper_limit_flag_o, 1'b1);
    shot(2'h0, 1'b0, 1'b1, 1'b1, 16'hFE00);
    check("therm clear", upper_limit_flag_o, 1'b0);
    check("therm lower", lower_limit_flag_o, 1'b0);
    check("therm pin", limit_event_pin_o, 1'b0);
    ev(4'h2);
    host.access(4'h8, mk(MODE_CONT, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0));
    wait_ready(100);
    t0 = cyc;
    ev(4'h2);
    wait_ready(100);
    check("cycle period", cyc - t0, CYCLE_MS[0] * MS);
    ev(4'h2);
    k = 0;
    while (state_o !== ST_ACTIVE && k < 100) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k >= 100) begin
      n_mismatch++;
      test_done();
    end
    host.access(4'h8, mk(MODE_SHUT, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0));
    repeat (3 * N) @(posedge clk_i);
    #1;
    check("abort state", state_o, ST_SHUT);
    check("abort ready", result_ready_flag_o, 1'b0);
    test_done();
  end
endmodule : testbench
